// *** testbench.sv ***
// Self-checking testbench for the partner emulation register bank
module testbench
  import vpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, reset, duplex_pin, strap_duplex_pol;
  logic        strap_speed, strap_manual_fc, req_valid, req_write;
  logic        req_serial, rsp_valid;
  logic [9:0]  req_addr;
  logic [31:0] req_wdata, rsp_data;
  int          err_total, checks_done;

  vpe_top #(.AN_RUN_CYCLES(1)) dut (
    .ref_clk(ref_clk), .reset(reset), .duplex_pin(duplex_pin),
    .strap_duplex_pol(strap_duplex_pol), .strap_speed(strap_speed),
    .strap_manual_fc(strap_manual_fc), .req_valid(req_valid),
    .req_write(req_write), .req_serial(req_serial), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  vpe_host host (
    .ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .req_valid(req_valid), .req_write(req_write), .req_serial(req_serial),
    .req_addr(req_addr), .req_wdata(req_wdata));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic ser, input logic [9:0] a,
                        input logic [31:0] exp);
    logic [31:0] rd;
    host.access(1'b0, ser, a, 32'h0, rd);
    check(rd, exp);
  endtask

  // Write, then let the emulated negotiation run finish
  task automatic wr_run(input logic [9:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    host.access(1'b1, 1'b0, a, wd, rd);
    check(rd, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] lp_exp(input logic sym, asym,
                                         input logic [3:0] abil);
    lp_exp = {16'h0, 4'h4, asym, sym ^ asym, 1'b0, abil, 5'h01};
  endfunction

  // Straps change after capture to show they are held
  task automatic do_reset(input logic pol, spd);
    @(posedge ref_clk);
    #1 reset = 1'b1;
    strap_duplex_pol = pol;
    strap_speed = spd;
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    @(posedge ref_clk);
    #1 strap_duplex_pol = ~pol;
    strap_speed = ~spd;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      strap_manual_fc = i[0];
      do_reset(i[0], i[1]);
      rd_chk(1'b0, LP_OFS, lp_exp(~i[0], 1'b0, 4'h1 << i));
      rd_chk(1'b1, {5'h0, EXP_IDX}, 32'h3);
      rd_chk(1'b0, EXP_OFS, 32'h1);
    end
  endtask

  task automatic t_pause();
    logic [31:0] w;
    for (int j = 0; j < 4; j++) begin
      w = {16'h0, 4'h0, j[1], j[0], 10'h1E1};
      wr_run(ADV_OFS, w | 32'hFFFF0000);
      rd_chk(1'b0, ADV_OFS, w);
      rd_chk(1'b1, {5'h0, LP_IDX}, lp_exp(j[0], j[1], 4'h8));
      rd_chk(1'b0, EXP_OFS, 32'h3);
    end
  endtask

  task automatic t_fail();
    wr_run(ADV_OFS, 32'h000000E1);
    rd_chk(1'b0, EXP_OFS, 32'h2);
    rd_chk(1'b1, {5'h0, EXP_IDX}, 32'h0);
    duplex_pin = 1'b0;
    wr_run(ADV_OFS, 32'h000000E1);
    rd_chk(1'b0, EXP_OFS, 32'h3);
    wr_run(LP_OFS, 32'h0000FFFF);
    rd_chk(1'b0, LP_OFS, lp_exp(1'b0, 1'b0, 4'h4));
    rd_chk(1'b0, 10'h1DC, 32'h0);
    rd_chk(1'b1, 10'h007, 32'h0);
  endtask

  // Second write lands inside the run and restarts it
  task automatic t_restart();
    logic [31:0] r0, r1;
    host.write_pair(ADV_OFS, 32'h000004E1, 32'h00000CE1, r0, r1);
    check(r0, 32'h0);
    check(r1, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    rd_chk(1'b0, LP_OFS, lp_exp(1'b1, 1'b1, 4'h4));
    rd_chk(1'b1, {5'h0, EXP_IDX}, 32'h3);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    reset = 1'b1;
    duplex_pin = 1'b1;
    strap_duplex_pol = 1'b0;
    strap_speed = 1'b0;
    strap_manual_fc = 1'b0;
    t_straps();
    t_pause();
    t_fail();
    t_restart();
    final_report();
  end
endmodule

// *** vpe_host.sv ***
// Management host model issuing register requests
module vpe_host
  import vpe_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_data,
  output logic             req_valid,
  output logic             req_write,
  output logic             req_serial,
  output logic      [9:0]  req_addr,
  output logic      [31:0] req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid  = 1'b0;
    req_write  = 1'b0;
    req_serial = 1'b0;
    req_addr   = 10'h3FF;
    req_wdata  = 32'h0;
  end

  // One request; answer read 1 ns after the taking edge
  task automatic access(input logic wr, ser, input logic [9:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd);
    req_valid  = 1'b1;
    req_write  = wr;
    req_serial = ser;
    req_addr   = adr;
    req_wdata  = wd;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    // Released address, data and write lines show the inverse, not stale values
    req_addr  = ~adr;
    req_wdata = ~wd;
    req_write = ~wr;
    // Missing answer shows as all ones
    rd = (rsp_valid === 1'b1) ? rsp_data : 32'hFFFFFFFF;
    @(posedge ref_clk);
    #1;
  endtask

  // Two memory writes on consecutive edges, strobe held between them
  task automatic write_pair(input logic [9:0] adr,
                            input logic [31:0] wd0, wd1,
                            output logic [31:0] rd0, rd1);
    req_valid  = 1'b1;
    req_write  = 1'b1;
    req_serial = 1'b0;
    req_addr   = adr;
    req_wdata  = wd0;
    @(posedge ref_clk);
    #1 req_wdata = wd1;
    rd0 = (rsp_valid === 1'b1) ? rsp_data : 32'hFFFFFFFF;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    req_addr  = ~adr;
    req_wdata = ~wd1;
    req_write = 1'b0;
    rd1 = (rsp_valid === 1'b1) ? rsp_data : 32'hFFFFFFFF;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// *** vpe_partner_calc.sv ***
// Combinational derivation of the emulated partner ability word
module vpe_partner_calc
  import vpe_pkg::*;
(
  input  wire logic [15:0] adv,
  input  wire logic        duplex_pin,
  input  wire logic        pol,
  input  wire logic        spd,
  output logic      [15:0] lp_word,
  output logic             an_ok
);

  logic [3:0] abil;
  logic       lp_sym;
  logic       lp_asym;

  always_comb begin
    abil    = vpe_abil(duplex_pin, pol, spd);
    lp_sym  = adv[ADV_SYM_BIT] ^ adv[ADV_ASYM_BIT];
    lp_asym = adv[ADV_ASYM_BIT];
    // No next page, ack set, no fault, no T4
    lp_word = {1'b0, 1'b1, 1'b0, 1'b0, lp_asym, lp_sym, 1'b0,
               abil, SELECTOR};
    an_ok   = |(adv[8:5] & abil);
  end

endmodule

// *** vpe_pkg.sv ***
// Constants and helpers for the virtual PHY partner emulation block
package vpe_pkg;

  // Memory-map byte offsets, one 32-bit word each
  localparam logic [9:0] ADV_OFS = 10'h1D0;
  localparam logic [9:0] LP_OFS  = 10'h1D4;
  localparam logic [9:0] EXP_OFS = 10'h1D8;

  // Management register indices
  localparam logic [4:0] ADV_IDX = 5'h04;
  localparam logic [4:0] LP_IDX  = 5'h05;
  localparam logic [4:0] EXP_IDX = 5'h06;

  // Field positions
  localparam int ADV_ASYM_BIT = 11;
  localparam int ADV_SYM_BIT  = 10;
  localparam int EXP_PAGE_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;

  // Values after reset and write masks
  localparam logic [15:0] ADV_RST     = 16'h01E1;
  localparam logic [15:0] ADV_WR_MASK = 16'h0DFF;
  localparam logic [15:0] LP_RST      = 16'h4001;
  localparam logic [4:0]  SELECTOR    = 5'h01;

  // Partner speed/duplex ability, bits 8..5
  localparam logic [3:0] ABIL_10FD  = 4'h2;
  localparam logic [3:0] ABIL_100FD = 4'h8;
  localparam logic [3:0] ABIL_10HD  = 4'h1;
  localparam logic [3:0] ABIL_100HD = 4'h4;

  // Cycles taken by one emulated negotiation run
  localparam int AN_RUN_CYCLES_DEF = 4;

  typedef enum logic [2:0] {
    ST_STRAP = 3'h1,
    ST_RUN   = 3'h2,
    ST_IDLE  = 3'h4
  } vpe_state_t;

  // Address hit, by byte offset or by management index
  function automatic logic vpe_hit(input logic       serial,
                                   input logic [9:0] addr,
                                   input logic [9:0] ofs,
                                   input logic [4:0] idx);
    vpe_hit = serial ? (addr == {5'h00, idx}) : (addr == ofs);
  endfunction

  // Partner speed/duplex from pin, polarity strap and speed strap
  function automatic logic [3:0] vpe_abil(input logic pin,
                                          input logic pol,
                                          input logic spd);
    if (pin == pol) begin
      vpe_abil = spd ? ABIL_100FD : ABIL_10FD;
    end else begin
      vpe_abil = spd ? ABIL_100HD : ABIL_10HD;
    end
  endfunction

endpackage

// *** vpe_top.sv ***
// Virtual PHY link partner emulation register bank
module vpe_top
  import vpe_pkg::*;
#(
  parameter int AN_RUN_CYCLES = AN_RUN_CYCLES_DEF
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        duplex_pin,
  input  wire logic        strap_duplex_pol,
  input  wire logic        strap_speed,
  input  wire logic        strap_manual_fc,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_serial,
  input  wire logic [9:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             rsp_valid,
  output logic      [31:0] rsp_data
);

  localparam int CW     = $clog2(AN_RUN_CYCLES + 1);
  localparam int AN_MAX = AN_RUN_CYCLES + 2;

  if (AN_RUN_CYCLES < 1) begin : g_chk
    $error("AN_RUN_CYCLES must be at least 1");
  end

  vpe_state_t  state_r;
  vpe_state_t  state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic        pol_r;
  logic        pol_nxt;
  logic        spd_r;
  logic        spd_nxt;
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;
  logic [15:0] lp_r;
  logic [15:0] lp_nxt;
  logic        page_r;
  logic        page_nxt;
  logic        lpan_r;
  logic        lpan_nxt;
  logic        rsp_valid_r;
  logic        rsp_valid_nxt;
  logic [31:0] rsp_data_r;
  logic [31:0] rsp_data_nxt;

  logic [15:0] lp_calc;
  logic        an_calc;
  logic        hit_adv;
  logic        hit_lp;
  logic        hit_exp;
  logic        adv_wr;
  logic        rd_exp;
  logic        fin;
  logic [15:0] exp_word;
  logic [31:0] rd_word;

  vpe_partner_calc u_calc (
    .adv        (adv_r),
    .duplex_pin (duplex_pin),
    .pol        (pol_r),
    .spd        (spd_r),
    .lp_word    (lp_calc),
    .an_ok      (an_calc)
  );

  // Address decode and read mux
  always_comb begin
    hit_adv  = vpe_hit(req_serial, req_addr, ADV_OFS, ADV_IDX);
    hit_lp   = vpe_hit(req_serial, req_addr, LP_OFS, LP_IDX);
    hit_exp  = vpe_hit(req_serial, req_addr, EXP_OFS, EXP_IDX);
    adv_wr   = req_valid && req_write && hit_adv;
    rd_exp   = req_valid && !req_write && hit_exp;
    fin      = (state_r == ST_RUN) && (cnt_r == '0);
    // Bits 4..2 constant zero
    exp_word = {11'h000, 3'h0, page_r, lpan_r};
    if (hit_adv) begin
      rd_word = {16'h0000, adv_r};
    end else if (hit_lp) begin
      rd_word = {16'h0000, lp_r};
    end else if (hit_exp) begin
      rd_word = {16'h0000, exp_word};
    end else begin
      rd_word = 32'h0000_0000;
    end
    if (req_serial) begin
      rd_word[31:16] = 16'h0000;
    end
  end

  // Strap capture, negotiation runs and register updates
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    pol_nxt       = pol_r;
    spd_nxt       = spd_r;
    adv_nxt       = adv_r;
    lp_nxt        = lp_r;
    page_nxt      = page_r;
    lpan_nxt      = lpan_r;
    rsp_valid_nxt = req_valid;
    rsp_data_nxt  = (req_valid && !req_write) ? rd_word : 32'h0000_0000;
    if (adv_wr) begin
      adv_nxt = (adv_r & ~ADV_WR_MASK) |
                (req_wdata[15:0] & ADV_WR_MASK);
    end
    if (rd_exp) begin
      page_nxt = 1'b0;
    end
    unique case (state_r)
      ST_STRAP: begin
        pol_nxt              = strap_duplex_pol;
        spd_nxt              = strap_speed;
        adv_nxt[ADV_SYM_BIT] = ~strap_manual_fc;
        cnt_nxt              = CW'(AN_RUN_CYCLES - 1);
        state_nxt            = ST_RUN;
      end
      ST_RUN: begin
        if (adv_wr) begin
          cnt_nxt = CW'(AN_RUN_CYCLES - 1);
        end else if (fin) begin
          lp_nxt    = lp_calc;
          lpan_nxt  = an_calc;
          page_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      ST_IDLE: begin
        if (adv_wr) begin
          cnt_nxt   = CW'(AN_RUN_CYCLES - 1);
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r     <= ST_STRAP;
      cnt_r       <= '0;
      pol_r       <= 1'b0;
      spd_r       <= 1'b0;
      adv_r       <= ADV_RST;
      lp_r        <= LP_RST;
      page_r      <= 1'b0;
      lpan_r      <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 32'h0000_0000;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      pol_r       <= pol_nxt;
      spd_r       <= spd_nxt;
      adv_r       <= adv_nxt;
      lp_r        <= lp_nxt;
      page_r      <= page_nxt;
      lpan_r      <= lpan_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r  <= rsp_data_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_data  = rsp_data_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_serial_half_word: assert property (
    req_valid && req_serial && !req_write |=> rsp_data[31:16] == 16'h0000
  ) else $error("serial read upper half not zero");

  a_partner_fixed_bits: assert property (
    state_r != ST_STRAP |-> lp_r[15:12] == 4'h4 && !lp_r[9]
  ) else $error("partner fixed bits wrong");

  a_pause_follow: assert property (
    fin && !adv_wr |=> lp_r[11] == $past(adv_r[11]) &&
      lp_r[10] == ($past(adv_r[10]) ^ $past(adv_r[11]))
  ) else $error("partner pause mapping wrong");

  a_ability_table: assert property (
    fin && !adv_wr |=>
      lp_r[8:5] == vpe_abil($past(duplex_pin), pol_r, spd_r)
  ) else $error("partner ability table wrong");

  a_strap_hold: assert property (
    state_r != ST_STRAP |=> $stable(pol_r) && $stable(spd_r)
  ) else $error("strap value changed after capture");

  a_exp_zero_bits: assert property (
    rd_exp |=> rsp_valid && rsp_data[31:2] == 30'h0
  ) else $error("expansion constant bits not zero");

  a_page_clear_read: assert property (
    rd_exp && !fin |=> !page_r
  ) else $error("page received not cleared by read");

  a_page_set_boot: assert property (
    $fell(reset) |-> ##[1:AN_MAX] page_r
  ) else $error("page received not set after reset");

  a_lpan_outcome: assert property (
    fin && !adv_wr |=> lpan_r == |($past(adv_r[8:5]) & lp_r[8:5])
  ) else $error("partner negotiation able wrong");

  a_lp_read_word: assert property (
    req_valid && !req_write && hit_lp |=> rsp_data == {16'h0, $past(lp_r)}
  ) else $error("partner ability read wrong");

  a_adv_rerun: assert property (
    adv_wr && state_r == ST_IDLE |=> state_r == ST_RUN ##AN_RUN_CYCLES
      state_r == ST_IDLE || adv_r != $past(adv_r)
  ) else $error("advertisement write did not rerun");

  a_adv_pause_wr: assert property (
    adv_wr && state_r != ST_STRAP |=>
      adv_r[11:10] == $past(req_wdata[11:10])
  ) else $error("pause bits not written");

  a_run_restart: assert property (
    adv_wr && state_r == ST_RUN |=> state_r == ST_RUN
  ) else $error("write inside a run did not restart it");

  c_run_done:   cover property (fin);
  c_page_read:  cover property (rd_exp && page_r);
  c_an_fail:    cover property (fin && !an_calc);
  c_serial_exp: cover property (rd_exp && req_serial);
  c_run_restart: cover property (adv_wr && state_r == ST_RUN);

endmodule
